// >>> rtl/three_phase_overcurrent_trip.sv
// three-phase time-overcurrent element with APB settings
//
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "overcurrent_consts.svh"
module three_phase_overcurrent_trip
   import overcurrent_pkg::*;
#(
   parameter int TICK_CYCLES = `MS_NS / `CLK_PERIOD_NS
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [15:0] phase_a_fundamental_mag,
   input wire logic [15:0] phase_b_fundamental_mag,
   input wire logic [15:0] phase_c_fundamental_mag,
   input wire logic block_input,
   output logic phase_a_start_flag,
   output logic phase_b_start_flag,
   output logic phase_c_start_flag,
   output logic phase_a_trip_flag,
   output logic phase_b_trip_flag,
   output logic phase_c_trip_flag,
   output logic general_start_out,
   output logic general_trip_out
);
   // curve constants: k and kr in ms scaled by 2^16, c in ms
   localparam logic [47:0] K_TAB [11] = '{
      48'h0000008C0000, 48'h000034BC0000, 48'h000138800000,
      48'h0001D4C00000, 48'h00000008999A, 48'h000000338000,
      48'h00004C9A0000, 48'h00006E280000, 48'h000000560000,
      48'h00006F860000, 48'h0000FA460000};
   localparam logic [15:0] C_TAB [11] = '{
      16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0013, 16'h0072,
      16'h01EB, 16'h007A, 16'h00B9, 16'h02C8, 16'h00FA};
   localparam logic [47:0] KR_TAB [11] = '{
      48'h0, 48'h0, 48'h0, 48'h0,
      48'h000001CC0000, 48'h000012F20000, 48'h000054600000,
      48'h000071AC0000, 48'h000011F80000, 48'h000034940000,
      48'h000075300000};
   // alpha: 0 means 0.02, 1 means 1, 2 means 2
   localparam logic [1:0] A_TAB [11] = '{
      2'h0, 2'h1, 2'h2, 2'h1, 2'h0, 2'h0, 2'h2, 2'h2, 2'h0, 2'h2, 2'h2};

   // settings over APB
   mode_t mode_reg;
   logic [15:0] pickup_reg, tms_reg, min_delay_reg;
   logic [15:0] def_delay_reg, reset_delay_reg;
   logic pready_reg, pslverr_reg;
   logic [31:0] prdata_reg;
   logic [2:0] start_reg, trip_reg;
   logic gen_start_reg, gen_trip_reg;

   wire logic access = psel && penable;
   wire logic wr_en = access && pwrite && pready_reg;
   wire logic hit_mode = paddr == `ADDR_MODE;
   wire logic hit_pickup = paddr == `ADDR_PICKUP;
   wire logic hit_tms = paddr == `ADDR_TMS;
   wire logic hit_min = paddr == `ADDR_MIN_DELAY;
   wire logic hit_def = paddr == `ADDR_DEF_DELAY;
   wire logic hit_rst = paddr == `ADDR_RESET_DELAY;
   wire logic hit_stat = paddr == `ADDR_STATUS;
   wire logic mapped = hit_mode | hit_pickup | hit_tms | hit_min |
                       hit_def | hit_rst | hit_stat;
   wire logic [15:0] wdata16 = pwdata[15:0];
   wire logic wide = pwdata[31:16] != 16'h0;

   function automatic logic [15:0] clamp16(input logic wd,
         input logic [15:0] v, input logic [15:0] lo,
         input logic [15:0] hi);
      if (wd || v > hi)
         return hi;
      else if (v < lo)
         return lo;
      else
         return v;
   endfunction

   // out-of-range writes are pulled to the nearest legal value
   wire logic [15:0] pickup_w =
      clamp16(wide, wdata16, `PICKUP_MIN, `PICKUP_MAX);
   wire logic [15:0] tms_w =
      clamp16(wide, wdata16, `TMS_MIN, `TMS_MAX);
   wire logic [15:0] min_w =
      clamp16(wide, wdata16, `DELAY_MIN, `DELAY_MAX);
   wire logic [15:0] def_w =
      clamp16(wide, wdata16, `DELAY_MIN, `DELAY_MAX);
   wire logic [15:0] rstd_w =
      clamp16(wide, wdata16, `RESET_MIN, `DELAY_MAX);
   // an unknown curve code falls back to off
   wire mode_t mode_w = (pwdata > 32'(MODE_ANSI_LONG_EXT)) ? MODE_OFF :
                        mode_t'(pwdata[3:0]);

   wire logic [31:0] rd_mux =
      hit_mode ? {28'h0, mode_reg} :
      hit_pickup ? {16'h0, pickup_reg} :
      hit_tms ? {16'h0, tms_reg} :
      hit_min ? {16'h0, min_delay_reg} :
      hit_def ? {16'h0, def_delay_reg} :
      hit_rst ? {16'h0, reset_delay_reg} :
      hit_stat ? {23'h0, block_input, gen_trip_reg, gen_start_reg,
                  trip_reg, start_reg} : 32'h0;

   // one wait state keeps prdata and pready straight from flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h0;
      end else begin
         pready_reg <= access && !pready_reg;
         pslverr_reg <= access && !pready_reg && !mapped;
         prdata_reg <= (access && !pready_reg && !pwrite) ? rd_mux : 32'h0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_reg <= MODE_OFF;
         pickup_reg <= `PICKUP_RST;
         tms_reg <= `TMS_RST;
         min_delay_reg <= `DELAY_RST;
         def_delay_reg <= `DELAY_RST;
         reset_delay_reg <= `DELAY_RST;
      end else if (wr_en) begin
         if (hit_mode) mode_reg <= mode_w;
         if (hit_pickup) pickup_reg <= pickup_w;
         if (hit_tms) tms_reg <= tms_w;
         if (hit_min) min_delay_reg <= min_w;
         if (hit_def) def_delay_reg <= def_w;
         if (hit_rst) reset_delay_reg <= rstd_w;
      end
   end

   // millisecond tick
   logic [31:0] tick_cnt_reg;
   wire logic tick = tick_cnt_reg == 32'(TICK_CYCLES - 1);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         tick_cnt_reg <= 32'h0;
      else
         tick_cnt_reg <= tick ? 32'h0 : tick_cnt_reg + 32'h1;
   end

   // curve evaluation sequencer
   wire logic [15:0] mag [3];
   assign mag[0] = phase_a_fundamental_mag;
   assign mag[1] = phase_b_fundamental_mag;
   assign mag[2] = phase_c_fundamental_mag;

   seq_state_t seq_reg;
   logic [1:0] ph_reg;
   logic pending_reg;
   logic [47:0] ratio_reg, stage_reg;
   logic [31:0] inv_ms_reg [3];
   logic [31:0] ans_rst_ms_reg [3];

   wire logic div_done;
   wire logic [47:0] div_q;
   wire logic inverse = mode_reg >= MODE_IEC_INV;
   wire logic ansi = mode_reg >= MODE_ANSI_INV;
   wire logic [3:0] ci = inverse ? 4'(mode_reg - MODE_IEC_INV) : 4'h0;

   // twenty times pickup is the end of the dependent range
   wire logic [47:0] ratio_c = (div_q > `RATIO_CLAMP) ? `RATIO_CLAMP :
                               div_q;
   wire logic [95:0] r_sq_w = ratio_reg * ratio_reg;
   wire logic [47:0] r_sq = r_sq_w[63:16];

   // r^0.02 - 1 taken as 0.02*ln(r), r near the usable range
   logic [4:0] msb;
   always_comb begin
      msb = 5'h10;
      for (int b = 16; b < 21; b++)
         if (ratio_reg[b]) msb = 5'(b);
   end
   wire logic [47:0] log2_q16 =
      {27'h0, msb - 5'h10, 16'h0} +
      ((ratio_reg >> (msb - 5'h10)) - `Q16_ONE);
   wire logic [95:0] lnx_w = log2_q16 * `LN2_ALPHA_Q16;
   wire logic [47:0] x_raw =
      (A_TAB[ci] == 2'h0) ? lnx_w[63:16] :
      (A_TAB[ci] == 2'h1) ? ratio_reg - `Q16_ONE : r_sq - `Q16_ONE;
   // below pickup the ANSI reset uses 1 - r^2
   wire logic [47:0] y_raw = `Q16_ONE - r_sq;
   wire logic [47:0] x_den = (x_raw == 48'h0) ? 48'h1 : x_raw;
   wire logic [47:0] y_den = (ratio_reg >= `Q16_ONE) ? 48'h1 : y_raw;
   wire logic [15:0] gs = pickup_reg;
   wire logic [95:0] op_scaled =
      (div_q + {32'h0, C_TAB[ci]}) * {32'h0, tms_reg};
   wire logic [95:0] rs_scaled = div_q * {32'h0, tms_reg};

   wire logic [47:0] div_num =
      (seq_reg == SQ_RATIO) ? {16'h0, mag[ph_reg], 16'h0} :
      (seq_reg == SQ_OPER) ? K_TAB[ci] :
      (seq_reg == SQ_RST) ? KR_TAB[ci] : stage_reg;
   wire logic [47:0] div_den =
      (seq_reg == SQ_RATIO) ? {32'h0, gs} :
      (seq_reg == SQ_OPER) ? x_den :
      (seq_reg == SQ_RST) ? y_den : `TMS_SCALE;
   wire logic div_start = (seq_reg != SQ_IDLE) && !pending_reg;
   wire logic [31:0] q_sat = (div_q[47:32] != 16'h0) ? `ELAPSED_MAX :
                             div_q[31:0];

   seq_divider u_div (
      .pclk(pclk),
      .presetn(presetn),
      .start(div_start),
      .dividend(div_num),
      .divisor(div_den),
      .done(div_done),
      .quotient(div_q)
   );

   // one divider is shared; a full pass takes well under a tick
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seq_reg <= SQ_IDLE;
         ph_reg <= 2'h0;
         pending_reg <= 1'b0;
         ratio_reg <= 48'h0;
         stage_reg <= 48'h0;
         for (int p = 0; p < 3; p++) begin
            inv_ms_reg[p] <= 32'h0;
            ans_rst_ms_reg[p] <= 32'h0;
         end
      end else begin
         if (div_start) pending_reg <= 1'b1;
         if (div_done) pending_reg <= 1'b0;
         unique case (seq_reg)
            SQ_IDLE: if (tick && inverse) begin
               seq_reg <= SQ_RATIO;
               ph_reg <= 2'h0;
            end
            SQ_RATIO: if (div_done) begin
               ratio_reg <= ratio_c;
               seq_reg <= SQ_OPER;
            end
            SQ_OPER: if (div_done) begin
               stage_reg <= (op_scaled[95:48] != 48'h0) ?
                            {48{1'b1}} : op_scaled[47:0];
               seq_reg <= SQ_SCALE;
            end
            SQ_SCALE: if (div_done) begin
               inv_ms_reg[ph_reg] <= q_sat;
               seq_reg <= ansi ? SQ_RST : SQ_IDLE;
               if (!ansi) begin
                  ph_reg <= ph_reg + 2'h1;
                  if (ph_reg != 2'h2) seq_reg <= SQ_RATIO;
               end
            end
            SQ_RST: if (div_done) begin
               stage_reg <= (rs_scaled[95:48] != 48'h0) ?
                            {48{1'b1}} : rs_scaled[47:0];
               seq_reg <= SQ_RSCALE;
            end
            SQ_RSCALE: if (div_done) begin
               ans_rst_ms_reg[ph_reg] <= q_sat;
               ph_reg <= ph_reg + 2'h1;
               seq_reg <= (ph_reg == 2'h2) ? SQ_IDLE : SQ_RATIO;
            end
         endcase
      end
   end

   // per-phase timing
   wire logic disabled = block_input ||
                         mode_reg == MODE_OFF;
   logic [2:0] start_next, trip_next;

   for (genvar p = 0; p < 3; p++) begin : g_phase
      logic [31:0] elapsed_reg, rst_cnt_reg;
      wire logic picked = mag[p] > gs;
      // the minimum delay only lengthens the curve time
      wire logic [31:0] min_ms = {16'h0, min_delay_reg};
      wire logic [31:0] inv_op = (min_ms > inv_ms_reg[p]) ? min_ms :
                                 inv_ms_reg[p];
      wire logic [31:0] op_ms = inverse ? inv_op :
                                {16'h0, def_delay_reg};
      wire logic [31:0] rst_ms = ansi ? ans_rst_ms_reg[p] :
                                 {16'h0, reset_delay_reg};
      assign start_next[p] = !disabled && picked;
      assign trip_next[p] = !disabled && picked &&
                            elapsed_reg >= op_ms;

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            elapsed_reg <= 32'h0;
            rst_cnt_reg <= 32'h0;
         end else if (disabled) begin
            elapsed_reg <= 32'h0;
            rst_cnt_reg <= 32'h0;
         end else if (tick) begin
            if (picked) begin
               rst_cnt_reg <= 32'h0;
               if (elapsed_reg != `ELAPSED_MAX)
                  elapsed_reg <= elapsed_reg + 32'h1;
            end else if (!inverse) begin
               elapsed_reg <= 32'h0;
            end else if (rst_cnt_reg + 32'h1 >= rst_ms) begin
               // timing memory is kept until the reset time runs out
               elapsed_reg <= 32'h0;
               rst_cnt_reg <= 32'h0;
            end else begin
               rst_cnt_reg <= rst_cnt_reg + 32'h1;
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         start_reg <= 3'h0;
         trip_reg <= 3'h0;
         gen_start_reg <= 1'b0;
         gen_trip_reg <= 1'b0;
      end else begin
         start_reg <= start_next;
         trip_reg <= trip_next;
         gen_start_reg <= |start_next;
         gen_trip_reg <= |trip_next;
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign phase_a_start_flag = start_reg[0];
   assign phase_b_start_flag = start_reg[1];
   assign phase_c_start_flag = start_reg[2];
   assign phase_a_trip_flag = trip_reg[0];
   assign phase_b_trip_flag = trip_reg[1];
   assign phase_c_trip_flag = trip_reg[2];
   assign general_start_out = gen_start_reg;
   assign general_trip_out = gen_trip_reg;
endmodule // three_phase_overcurrent_trip

// >>> rtl/overcurrent_consts.svh
// constants for the three-phase time-overcurrent trip element
// Notes on behaviour
// - each phase judged on its own current
// - start while picked up, trip after delay
// - general start and trip from phase flags
// - blocking input disables the whole element
// - mode: off, definite, eleven curves; off default
// - pickup percent, 10 to 3000, default 200
// - time multiplier 0.05 to 15.00, step 0.01
// - minimum inverse delay 40 to 60000 ms
// - definite delay 40 to 60000 ms
// - IEC reset delay 60 to 60000 ms
// - inverse time from curve constants k, c, alpha
// - ratio clamped at twenty times pickup
// - minimum delay used when longer than curve
// - IEC fixed reset, ANSI reset from kr formula
`ifndef OVERCURRENT_CONSTS_SVH
`define OVERCURRENT_CONSTS_SVH

`define CLK_PERIOD_NS 4
`define MS_NS 1000000

`define ADDR_MODE 12'h000
`define ADDR_PICKUP 12'h004
`define ADDR_TMS 12'h008
`define ADDR_MIN_DELAY 12'h00C
`define ADDR_DEF_DELAY 12'h010
`define ADDR_RESET_DELAY 12'h014
`define ADDR_STATUS 12'h018

`define PICKUP_MIN 16'h000A
`define PICKUP_MAX 16'h0BB8
`define PICKUP_RST 16'h00C8
`define TMS_MIN 16'h0005
`define TMS_MAX 16'h05DC
`define TMS_RST 16'h0064
`define DELAY_MIN 16'h0028
`define DELAY_MAX 16'hEA60
`define RESET_MIN 16'h003C
`define DELAY_RST 16'h0064

`define Q16_ONE 48'h000000010000
`define RATIO_CLAMP 48'h000000140000
`define LN2_ALPHA_Q16 48'h00000000038C
`define TMS_SCALE 48'h000000000064
`define DIV_BITS 6'h30
`define ELAPSED_MAX 32'hFFFFFFFF

`endif

// >>> rtl/overcurrent_pkg.sv
// types shared by the overcurrent trip element
package overcurrent_pkg;
   typedef enum logic [3:0] {
      MODE_OFF, MODE_DEFINITE,
      MODE_IEC_INV, MODE_IEC_VERY, MODE_IEC_EXT, MODE_IEC_LONG,
      MODE_ANSI_INV, MODE_ANSI_MOD, MODE_ANSI_VERY, MODE_ANSI_EXT,
      MODE_ANSI_LONG, MODE_ANSI_LONG_VERY, MODE_ANSI_LONG_EXT
   } mode_t;
   typedef enum logic [2:0] {
      SQ_IDLE, SQ_RATIO, SQ_OPER, SQ_SCALE, SQ_RST, SQ_RSCALE
   } seq_state_t;
endpackage

// >>> rtl/seq_divider.sv
// restoring unsigned divider, one quotient bit per clock
`timescale 1ns/1ps
`include "overcurrent_consts.svh"
module seq_divider (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic start,
   input wire logic [47:0] dividend,
   input wire logic [47:0] divisor,
   output logic done,
   output logic [47:0] quotient
);
   logic [48:0] rem_reg;
   logic [47:0] quo_reg;
   logic [5:0] cnt_reg;
   logic busy_reg;
   logic done_reg;
   wire logic [48:0] shifted = {rem_reg[47:0], quo_reg[47]};
   wire logic fits = shifted >= {1'b0, divisor};
   wire logic [48:0] diff = shifted - {1'b0, divisor};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rem_reg <= 49'h0;
         quo_reg <= 48'h0;
         cnt_reg <= 6'h0;
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
      end else begin
         done_reg <= 1'b0;
         if (start) begin
            rem_reg <= 49'h0;
            quo_reg <= dividend;
            cnt_reg <= `DIV_BITS;
            busy_reg <= 1'b1;
         end else if (busy_reg) begin
            rem_reg <= fits ? diff : shifted;
            quo_reg <= {quo_reg[46:0], fits};
            cnt_reg <= cnt_reg - 6'h1;
            if (cnt_reg == 6'h1) begin
               busy_reg <= 1'b0;
               done_reg <= 1'b1;
            end
         end
      end
   end

   assign done = done_reg;
   assign quotient = quo_reg;
endmodule // seq_divider

// >>> tb/overcurrent_chk.sv
// port-level assertions for the three-phase overcurrent trip element
`timescale 1ns/1ps
module overcurrent_chk #(
   parameter int TICK_CYCLES = 20
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [15:0] phase_a_fundamental_mag,
   input wire logic [15:0] phase_b_fundamental_mag,
   input wire logic [15:0] phase_c_fundamental_mag,
   input wire logic block_input,
   input wire logic phase_a_start_flag,
   input wire logic phase_b_start_flag,
   input wire logic phase_c_start_flag,
   input wire logic phase_a_trip_flag,
   input wire logic phase_b_trip_flag,
   input wire logic phase_c_trip_flag,
   input wire logic general_start_out,
   input wire logic general_trip_out
);
   wire logic [2:0] st_vec = {phase_c_start_flag, phase_b_start_flag,
      phase_a_start_flag};
   wire logic [2:0] tr_vec = {phase_c_trip_flag, phase_b_trip_flag,
      phase_a_trip_flag};
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence setup_then_access;
      (psel && !penable) ##1 (psel && penable);
   endsequence
   access_wait_a:
   assert property (setup_then_access |-> !pready ##1 pready)
      else $error("ready not in second access cycle");
   ready_pulse_a:
   assert property (pready |=> !pready)
      else $error("ready held longer than one cycle");
   err_ready_a:
   assert property (pslverr |-> pready)
      else $error("error response without ready");
   rdata_idle_a:
   assert property (!pready |-> prdata == 32'h0)
      else $error("read data driven outside a response");
   gen_start_or_a:
   assert property (general_start_out == (|st_vec))
      else $error("general start differs from phase starts");
   gen_trip_or_a:
   assert property (general_trip_out == (|tr_vec))
      else $error("general trip differs from phase trips");
   block_clear_a:
   assert property (block_input |=> st_vec == 3'h0 && tr_vec == 3'h0)
      else $error("flag active while blocked");
   trip_start_a:
   assert property ((tr_vec & ~st_vec) == 3'h0)
      else $error("phase trip without its start");
   zero_mag_a:
   assert property (phase_a_fundamental_mag == 16'h0 |=> !phase_a_start_flag)
      else $error("phase a started with no current");
   unblock_quiet_a:
   assert property ($fell(block_input) |-> !general_trip_out [*2])
      else $error("trip right after unblocking");
endmodule // overcurrent_chk

// >>> tb/meas_stage.sv
// behavioural measurement stage delivering the three phase magnitudes
`timescale 1ns/1ps
module meas_stage (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic slow,
   input wire logic [2:0][15:0] tgt,
   output logic [2:0][15:0] mag
);
   // slow mode ramps like a settling filter, so pickup is seen late
   function automatic logic [15:0] step(input logic [15:0] m, t);
      if (m + 16'h0040 < t) return m + 16'h0040;
      if (t + 16'h0040 < m) return m - 16'h0040;
      return t;
   endfunction
   always_ff @(posedge pclk or negedge presetn) begin
      for (int i = 0; i < 3; i++) begin
         if (!presetn) mag[i] <= 16'h0000;
         else mag[i] <= slow ? step(mag[i], tgt[i]) : tgt[i];
      end
   end
endmodule // meas_stage

// >>> tb/three_phase_overcurrent_trip_test.sv
// self-checking bench for the three-phase overcurrent trip element
`timescale 1ns/1ps
module three_phase_overcurrent_trip_test;
   localparam int TICK = 20;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, block_input = 1'b0, slow = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h262C;
   logic pready, pslverr, err, general_start_out, general_trip_out;
   logic [2:0][15:0] tgt = '0, mag, t;
   logic [2:0] st, tr, exp_st;
   int num_errors = 0, n_compared = 0, sh_mode = 0, sh_pick = 200, n;
   logic [11:0] ra [6] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010,
      12'h014};
   int rst_v [6] = '{0, 200, 100, 100, 100, 100};
   int lo_v [6] = '{0, 10, 5, 40, 40, 60};
   int hi_v [6] = '{12, 3000, 1500, 60000, 60000, 60000};
   always #2 pclk = ~pclk;
   three_phase_overcurrent_trip #(.TICK_CYCLES(TICK))
   three_phase_overcurrent_trip_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr),
      .phase_a_fundamental_mag(mag[0]), .phase_b_fundamental_mag(mag[1]),
      .phase_c_fundamental_mag(mag[2]), .block_input(block_input),
      .phase_a_start_flag(st[0]), .phase_b_start_flag(st[1]),
      .phase_c_start_flag(st[2]), .phase_a_trip_flag(tr[0]),
      .phase_b_trip_flag(tr[1]), .phase_c_trip_flag(tr[2]),
      .general_start_out(general_start_out),
      .general_trip_out(general_trip_out));
   meas_stage meas_stage_inst (.pclk(pclk), .presetn(presetn),
      .slow(slow), .tgt(tgt), .mag(mag));
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   function automatic int clampv(input logic [31:0] v, input int lo, hi);
      return v < lo ? lo : (v > hi ? hi : int'(v));
   endfunction
   task automatic wrap_up;
      if (num_errors == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic check_val(input logic [31:0] got, want, input string s);
      n_compared++;
      if (got !== want) begin
         num_errors++;
         $display("MISMATCH %0t %s got %0h want %0h", $time, s, got, want);
      end
   endtask
   task automatic check_time(input int got, lo, hi);
      n_compared++;
      if (got < lo || got > hi) begin
         num_errors++;
         $display("MISMATCH %0t trip after %0d cycles", $time, got);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a,
         input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (!pready && k < 16);
      if (!pready) begin
         num_errors++;
         wrap_up();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // shadow settings follow the write one edge late, like the flops
      if (wr && !err && a == 12'h000) sh_mode <= d > 12 ? 0 : int'(d);
      if (wr && !err && a == 12'h004) sh_pick <= clampv(d, 10, 3000);
   endtask
   task automatic hold(input int c);
      repeat (c) @(posedge pclk);
   endtask
   // reference flags: strict pickup, gated by mode and blocking
   always @(posedge pclk or negedge presetn) begin
      for (int i = 0; i < 3; i++) begin
         if (!presetn) exp_st[i] <= 1'b0;
         else exp_st[i] <= sh_mode != 0 && !block_input && mag[i] > sh_pick;
      end
   end
   always @(negedge pclk) begin
      if (presetn) begin
         check_val(32'(st), 32'(exp_st), "start flags");
         check_val(32'(general_start_out), 32'(|exp_st), "gen");
      end
   end
   initial begin
      hold(8);
      presetn <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         apb(1'b0, ra[i], 32'h0);
         check_val(rd, rst_v[i], "reset value");
         apb(1'b1, ra[i], 32'(lo_v[i] - 1));
         apb(1'b0, ra[i], 32'h0);
         check_val(rd, lo_v[i], "low clamp");
         apb(1'b1, ra[i], 32'(hi_v[i] + 1));
         apb(1'b0, ra[i], 32'h0);
         check_val(rd, i == 0 ? 0 : hi_v[i], "high clamp");
      end
      apb(1'b0, 12'h01C, 32'h0);
      check_val({rd[30:0], err}, 32'h1, "unmapped read");
      apb(1'b1, 12'h018, 32'hFFFF);
      check_val(32'(err), 32'h0, "status write");
      apb(1'b1, 12'h004, 32'h0C8);
      apb(1'b1, 12'h010, 32'h028);
      apb(1'b1, 12'h000, 32'h001);
      for (int p = 0; p < 3; p++) begin
         t = {3{16'h00C8}};
         t[p] = 16'h00C9;
         tgt <= t;
         n = 0;
         while (!general_trip_out && n < 50 * TICK) begin
            @(posedge pclk);
            n++;
         end
         check_time(n, 39 * TICK, 42 * TICK);
         check_val(32'(tr), 32'(1 << p), "phase trip");
         tgt <= '0;
         hold(4);
         check_val(32'(tr), 32'h0, "trip drop");
      end
      tgt <= {16'h0384, 16'h0000, 16'h0000};
      hold(4);
      block_input <= 1'b1;
      hold(4);
      apb(1'b0, 12'h018, 32'h0);
      check_val(rd, 32'h100, "blocked status");
      block_input <= 1'b0;
      hold(4);
      apb(1'b0, 12'h018, 32'h0);
      check_val(rd, 32'h44, "started status");
      apb(1'b1, 12'h000, 32'h0);
      hold(4);
      apb(1'b0, 12'h018, 32'h0);
      check_val(rd, 32'h0, "off status");
      // ratio 30 is clamped to 20: 0.30 * 13.5 / 19 s is 213 ms
      // min delay 100 ms outlasts the first curve pass, yet is shorter
      tgt <= {16'h0000, 16'h1770, 16'h0000};
      apb(1'b1, 12'h00C, 32'h064);
      apb(1'b1, 12'h008, 32'h01E);
      apb(1'b1, 12'h000, 32'h003);
      n = 0;
      while (!general_trip_out && n < 250 * TICK) begin
         @(posedge pclk);
         n++;
      end
      check_time(n, 212 * TICK, 216 * TICK);
      check_val(32'(tr), 32'h2, "inverse trip");
      tgt <= '0;
      hold(4);
      check_val(32'(tr), 32'h0, "inverse drop");
      slow <= 1'b1;
      for (int i = 0; i < 26; i++) begin
         seed = xs(seed);
         apb(1'b1, 12'h004, 32'(10 + seed % 2991));
         apb(1'b1, 12'h000, 32'(i % 13));
         seed = xs(seed);
         t = {4'h0, seed[31:20], 4'h0, seed[19:8], 8'h00, seed[7:0]};
         tgt <= t;
         block_input <= seed[4:2] == 3'h0;
         hold(40);
      end
      wrap_up();
   end
endmodule // three_phase_overcurrent_trip_test
bind three_phase_overcurrent_trip overcurrent_chk #(
   .TICK_CYCLES(TICK_CYCLES)) chk_inst (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr),
   .phase_a_fundamental_mag(phase_a_fundamental_mag),
   .phase_b_fundamental_mag(phase_b_fundamental_mag),
   .phase_c_fundamental_mag(phase_c_fundamental_mag),
   .block_input(block_input), .phase_a_start_flag(phase_a_start_flag),
   .phase_b_start_flag(phase_b_start_flag),
   .phase_c_start_flag(phase_c_start_flag),
   .phase_a_trip_flag(phase_a_trip_flag),
   .phase_b_trip_flag(phase_b_trip_flag),
   .phase_c_trip_flag(phase_c_trip_flag),
   .general_start_out(general_start_out),
   .general_trip_out(general_trip_out));
